// ==== logic/alu_add_and_shift_subset.sv ====
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "alu_subset_defs.svh"

module alu_add_and_shift_subset (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);

    function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? wdata[15:8] : old_val[15:8], be[0] ? wdata[7:0] : old_val[7:0]};
    endfunction : merge16

    alu_subset_pkg::exec_state_type state_q;
    alu_subset_pkg::cmd_type        cmd_q;
    alu_subset_pkg::alu_in_type     alu_in;
    alu_subset_pkg::alu_out_type    alu_out;
    alu_subset_pkg::op_type         last_op_q;

    logic [7:0]  acc_q;
    logic        c_q;
    logic        dc_q;
    logic        z_q;
    logic [15:0] ptr_q [2];
    logic [6:0]  file_addr_q;
    logic [7:0]  file_q [128];
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    logic        bus_req;
    logic        accept;
    logic        bus_wr;
    logic        exec;
    logic        be_byte;
    logic [7:0]  file_rd;
    logic [15:0] ptr_sext;
    logic [15:0] ptr_sum;
    logic [7:0]  alu_res;
    logic        dc_exp;

    assign bus_req = avs_read | avs_write;
    // Bus stalls while an instruction executes, so no software write races it
    assign accept  = bus_req && wait_q && (state_q == alu_subset_pkg::ST_IDLE);
    assign bus_wr  = avs_write && !wait_q;
    assign be_byte = avs_byteenable[0];
    assign exec    = (state_q == alu_subset_pkg::ST_EXEC);
    assign file_rd = file_q[cmd_q.file_addr];

    assign ptr_sext = {{10{cmd_q.literal[5]}}, cmd_q.literal[5:0]};
    assign ptr_sum  = ptr_q[cmd_q.ptr_sel] + ptr_sext;
    assign alu_res  = alu_out.result;
    assign dc_exp   = ({1'b0, acc_q[3:0]} + {1'b0, cmd_q.literal[3:0]}) > 5'h0F;

    assign alu_in.op       = cmd_q.op;
    assign alu_in.acc      = acc_q;
    assign alu_in.file_val = file_rd;
    assign alu_in.literal  = cmd_q.literal;
    assign alu_in.carry    = c_q;

    alu_unit u_alu (
        .alu_in  (alu_in),
        .alu_out (alu_out)
    );

    // Bus handshake: waitrequest drops for exactly one cycle per access
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else if (accept) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (avs_address)
            `OFS_ACC:       rdata_d[7:0] = acc_q;
            `OFS_FLAGS: begin
                rdata_d[`FLAG_C_BIT]  = c_q;
                rdata_d[`FLAG_DC_BIT] = dc_q;
                rdata_d[`FLAG_Z_BIT]  = z_q;
            end
            `OFS_PTR0:      rdata_d[15:0] = ptr_q[0];
            `OFS_PTR1:      rdata_d[15:0] = ptr_q[1];
            `OFS_CMD:       rdata_d[`CMD_PSEL_BIT:0] = cmd_q;
            `OFS_FILE_ADDR: rdata_d[6:0] = file_addr_q;
            `OFS_FILE_DATA: rdata_d[7:0] = file_q[file_addr_q];
            `OFS_STATE: begin
                rdata_d[`STATE_BUSY_BIT] = exec;
                rdata_d[`STATE_OP_MSB:`STATE_OP_LSB] = last_op_q;
            end
            default:        rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (accept && avs_read) begin
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= alu_subset_pkg::ST_IDLE;
        end else begin
            case (state_q)
                alu_subset_pkg::ST_IDLE: begin
                    if (bus_wr && avs_address == `OFS_CMD && avs_byteenable[2:0] == 3'h7) begin
                        state_q <= alu_subset_pkg::ST_EXEC;
                    end
                end
                alu_subset_pkg::ST_EXEC: state_q <= alu_subset_pkg::ST_IDLE;
                default:                 state_q <= alu_subset_pkg::ST_IDLE;
            endcase
        end
    end

    // Partial command writes are ignored; a half-written command would execute garbage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= '0;
        end else if (bus_wr && avs_address == `OFS_CMD && avs_byteenable[2:0] == 3'h7) begin
            cmd_q <= avs_writedata[`CMD_PSEL_BIT:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_op_q <= alu_subset_pkg::OP_NONE;
        end else if (exec) begin
            last_op_q <= cmd_q.op;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= `RST_ACC;
        end else if (exec && (alu_out.to_acc || (alu_out.to_file && !cmd_q.dest))) begin
            acc_q <= alu_out.result;
        end else if (bus_wr && avs_address == `OFS_ACC && be_byte) begin
            acc_q <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            c_q  <= 1'b0;
            dc_q <= 1'b0;
            z_q  <= 1'b0;
        end else if (exec) begin
            if (alu_out.upd_c) begin
                c_q <= alu_out.c;
            end
            if (alu_out.upd_dc) begin
                dc_q <= alu_out.dc;
            end
            if (alu_out.upd_z) begin
                z_q <= alu_out.z;
            end
        end else if (bus_wr && avs_address == `OFS_FLAGS && be_byte) begin
            c_q  <= avs_writedata[`FLAG_C_BIT];
            dc_q <= avs_writedata[`FLAG_DC_BIT];
            z_q  <= avs_writedata[`FLAG_Z_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q[0] <= `RST_PTR;
            ptr_q[1] <= `RST_PTR;
        end else if (exec && cmd_q.op == alu_subset_pkg::OP_POINTER_ADD_LITERAL) begin
            ptr_q[cmd_q.ptr_sel] <= ptr_sum;
        end else if (bus_wr && avs_address == `OFS_PTR0) begin
            ptr_q[0] <= merge16(ptr_q[0], avs_writedata, avs_byteenable);
        end else if (bus_wr && avs_address == `OFS_PTR1) begin
            ptr_q[1] <= merge16(ptr_q[1], avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_addr_q <= `RST_FILE_ADDR;
        end else if (bus_wr && avs_address == `OFS_FILE_ADDR && be_byte) begin
            file_addr_q <= avs_writedata[6:0];
        end
    end

    // File contents are data, not control, so they carry no reset
    always_ff @(posedge ref_clk) begin
        if (exec && alu_out.to_file && cmd_q.dest) begin
            file_q[cmd_q.file_addr] <= alu_out.result;
        end else if (bus_wr && avs_address == `OFS_FILE_DATA && be_byte) begin
            file_q[file_addr_q] <= avs_writedata[7:0];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cmd_write;
        bus_wr && avs_address == `OFS_CMD && avs_byteenable[2:0] == 3'h7;
    endsequence

    sequence s_exec_once;
        exec ##1 !exec;
    endsequence

    a_cmd_then_exec: assert property (s_cmd_write |=> s_exec_once)
        else $error("command write did not execute exactly one cycle");

    a_ptr_add_sum: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_POINTER_ADD_LITERAL
        |=> (cmd_q.ptr_sel ? ptr_q[1] : ptr_q[0]) == $past(ptr_sum))
        else $error("pointer pair not updated with sign-extended sum");

    a_ptr_flags_kept: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_POINTER_ADD_LITERAL
        |=> $stable(c_q) && $stable(dc_q) && $stable(z_q) && $stable(acc_q))
        else $error("pointer add disturbed flags or accumulator");

    a_and_lit_result: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_AND_LITERAL_TO_ACC
        |=> acc_q == ($past(acc_q) & cmd_q.literal) && $stable(c_q) && $stable(dc_q))
        else $error("and literal result or flags wrong");

    a_add_lit_sum: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_ADD_LITERAL_TO_ACC
        |=> {c_q, acc_q} == {1'b0, $past(acc_q)} + {1'b0, cmd_q.literal})
        else $error("add literal sum or carry wrong");

    a_and_file_dest: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_AND_ACC_WITH_FILE && cmd_q.dest
        |=> file_q[cmd_q.file_addr] == ($past(acc_q) & $past(file_rd)) && $stable(acc_q)
            && $stable(c_q))
        else $error("and with file not stored back to file");

    a_add_file_route: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_ADD_ACC_TO_FILE && !cmd_q.dest
        |=> acc_q == $past(acc_q) + $past(file_rd) && $stable(file_rd))
        else $error("add file sum not routed to accumulator");

    a_shift_result: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_ARITH_SHIFT_RIGHT_FILE && cmd_q.dest
        |=> file_rd == {$past(file_rd[7]), $past(file_rd[7:1])} && c_q == $past(file_rd[0]))
        else $error("arithmetic shift result or carry wrong");

    a_shift_flags: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_ARITH_SHIFT_RIGHT_FILE && !cmd_q.dest
        |=> $stable(dc_q) && acc_q == $past(alu_res) && $stable(file_rd))
        else $error("shift touched digit carry or misrouted");

    a_addc_sum: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_ADD_ACC_FILE_WITH_CARRY && !cmd_q.dest
        |=> {c_q, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(file_rd)} + {8'h00, $past(c_q)})
        else $error("add with carry sum wrong");

    a_zero_flag: assert property (
        exec && cmd_q.op inside {[alu_subset_pkg::OP_AND_LITERAL_TO_ACC:
                                  alu_subset_pkg::OP_ADD_ACC_FILE_WITH_CARRY]}
        |=> z_q == ($past(alu_res) == 8'h00))
        else $error("zero flag does not match result");

    a_digit_carry: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_ADD_LITERAL_TO_ACC
        |=> dc_q == $past(dc_exp))
        else $error("digit carry not taken from bit 3");

    a_and_acc_route: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_AND_ACC_WITH_FILE && !cmd_q.dest
        |=> acc_q == ($past(acc_q) & $past(file_rd)) && $stable(file_rd) && $stable(c_q))
        else $error("and with file not routed to accumulator");

    a_add_file_dest: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_ADD_ACC_TO_FILE && cmd_q.dest
        |=> {c_q, file_rd} == {1'b0, $past(acc_q)} + {1'b0, $past(file_rd)} && $stable(acc_q))
        else $error("add file sum not stored back to file");

    a_addc_file_dest: assert property (
        exec && cmd_q.op == alu_subset_pkg::OP_ADD_ACC_FILE_WITH_CARRY && cmd_q.dest
        |=> {c_q, file_rd} == {1'b0, $past(acc_q)} + {1'b0, $past(file_rd)} + {8'h00, $past(c_q)}
            && $stable(acc_q))
        else $error("add with carry not stored back to file");

    a_wait_one_cycle: assert property (!wait_q |=> wait_q)
        else $error("waitrequest low for more than one cycle");

endmodule : alu_add_and_shift_subset

// ==== logic/alu_subset_defs.svh ====
`ifndef ALU_SUBSET_DEFS_SVH
`define ALU_SUBSET_DEFS_SVH

// Register byte offsets
`define OFS_ACC        8'h00
`define OFS_FLAGS      8'h04
`define OFS_PTR0       8'h08
`define OFS_PTR1       8'h0C
`define OFS_CMD        8'h10
`define OFS_FILE_ADDR  8'h14
`define OFS_FILE_DATA  8'h18
`define OFS_STATE      8'h1C

// Flag register bit positions
`define FLAG_C_BIT     0
`define FLAG_DC_BIT    1
`define FLAG_Z_BIT     2

// Command word field positions
`define CMD_OP_LSB     0
`define CMD_OP_MSB     3
`define CMD_LIT_LSB    4
`define CMD_LIT_MSB    11
`define CMD_FILE_LSB   12
`define CMD_FILE_MSB   18
`define CMD_DEST_BIT   19
`define CMD_PSEL_BIT   20

// State register fields
`define STATE_BUSY_BIT 0
`define STATE_OP_LSB   4
`define STATE_OP_MSB   7

// Reset values
`define RST_ACC        8'h00
`define RST_PTR        16'h0000
`define RST_FILE_ADDR  7'h00

`endif

// ==== logic/alu_subset_pkg.sv ====
package alu_subset_pkg;

    typedef enum logic [3:0] {
        OP_NONE                    = 4'h0,
        OP_POINTER_ADD_LITERAL     = 4'h1,
        OP_AND_LITERAL_TO_ACC      = 4'h2,
        OP_ADD_LITERAL_TO_ACC      = 4'h3,
        OP_AND_ACC_WITH_FILE       = 4'h4,
        OP_ADD_ACC_TO_FILE         = 4'h5,
        OP_ARITH_SHIFT_RIGHT_FILE  = 4'h6,
        OP_ADD_ACC_FILE_WITH_CARRY = 4'h7
    } op_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } exec_state_type;

    typedef struct packed {
        logic       ptr_sel;
        logic       dest;
        logic [6:0] file_addr;
        logic [7:0] literal;
        op_type     op;
    } cmd_type;

    typedef struct packed {
        op_type     op;
        logic [7:0] acc;
        logic [7:0] file_val;
        logic [7:0] literal;
        logic       carry;
    } alu_in_type;

    typedef struct packed {
        logic [7:0] result;
        logic       c;
        logic       dc;
        logic       z;
        logic       upd_c;
        logic       upd_dc;
        logic       upd_z;
        logic       to_acc;
        logic       to_file;
    } alu_out_type;

endpackage : alu_subset_pkg

// ==== logic/alu_unit.sv ====
`timescale 1ns/1ps

module alu_unit (
    input  wire alu_subset_pkg::alu_in_type  alu_in,
    output alu_subset_pkg::alu_out_type      alu_out
);

    // Returns {carry out of bit 7, carry out of bit 3, sum}
    function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        add8 = {hi[4], lo[4], hi[3:0], lo[3:0]};
    endfunction : add8

    logic [9:0] sum;

    // File-sourced results: the destination bit later picks file or accumulator
    always_comb begin
        sum     = 10'h000;
        alu_out = '0;
        case (alu_in.op)
            alu_subset_pkg::OP_AND_LITERAL_TO_ACC: begin
                alu_out.result = alu_in.acc & alu_in.literal;
                alu_out.upd_z  = 1'b1;
                alu_out.to_acc = 1'b1;
            end
            alu_subset_pkg::OP_ADD_LITERAL_TO_ACC: begin
                sum = add8(alu_in.acc, alu_in.literal, 1'b0);
                alu_out.upd_c  = 1'b1;
                alu_out.upd_dc = 1'b1;
                alu_out.upd_z  = 1'b1;
                alu_out.to_acc = 1'b1;
            end
            alu_subset_pkg::OP_AND_ACC_WITH_FILE: begin
                alu_out.result = alu_in.acc & alu_in.file_val;
                alu_out.upd_z  = 1'b1;
                alu_out.to_file = 1'b1;
            end
            alu_subset_pkg::OP_ADD_ACC_TO_FILE: begin
                sum = add8(alu_in.acc, alu_in.file_val, 1'b0);
                alu_out.to_file = 1'b1;
                alu_out.upd_c  = 1'b1;
                alu_out.upd_dc = 1'b1;
                alu_out.upd_z  = 1'b1;
            end
            alu_subset_pkg::OP_ARITH_SHIFT_RIGHT_FILE: begin
                alu_out.result = {alu_in.file_val[7], alu_in.file_val[7:1]};
                alu_out.c      = alu_in.file_val[0];
                alu_out.upd_c  = 1'b1;
                alu_out.upd_z  = 1'b1;
                alu_out.to_file = 1'b1;
            end
            alu_subset_pkg::OP_ADD_ACC_FILE_WITH_CARRY: begin
                sum = add8(alu_in.acc, alu_in.file_val, alu_in.carry);
                alu_out.to_file = 1'b1;
                alu_out.upd_c  = 1'b1;
                alu_out.upd_dc = 1'b1;
                alu_out.upd_z  = 1'b1;
            end
            default: begin
                alu_out = '0;
            end
        endcase
        if (alu_in.op == alu_subset_pkg::OP_ADD_LITERAL_TO_ACC ||
            alu_in.op == alu_subset_pkg::OP_ADD_ACC_TO_FILE ||
            alu_in.op == alu_subset_pkg::OP_ADD_ACC_FILE_WITH_CARRY) begin
            alu_out.result = sum[7:0];
            alu_out.c      = sum[9];
            alu_out.dc     = sum[8];
        end
        alu_out.z = (alu_out.result == 8'h00);
    end

endmodule : alu_unit

// ==== test/tb.sv ====
`timescale 1ns/1ps
`include "alu_subset_defs.svh"

module tb;
    logic        ref_clk;
    logic        rst_n;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] exp_q [$];
    int          bad_count;
    int          compares;
    logic [7:0]  model_acc;
    logic [2:0]  model_flags;
    logic [15:0] model_ptr [2];
    logic [7:0]  model_file [128];
    logic [3:0]  model_op;
    logic [6:0]  rand_fa;

    alu_add_and_shift_subset uut (
        .ref_clk         (ref_clk),
        .rst_n           (rst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task conclude;
        // A read that never came back leaves its note behind
        if (exp_q.size() != 0)
            bad_count++;
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task check(input logic [31:0] seen, input logic [31:0] expv);
        compares++;
        if (seen !== expv) begin
            bad_count++;
            $display("MISMATCH t=%0t read %h expected %h", $time, seen, expv);
        end
    endtask : check

    // Each bus task starts one edge late so no strobe is driven twice in a time step
    task bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : bus_wr

    task bus_rd(input logic [7:0] a, input logic [31:0] expv);
        exp_q.push_back(expv);
        @(posedge ref_clk);
        avs_address    <= a;
        avs_byteenable <= 4'hF;
        avs_read       <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
    endtask : bus_rd

    // Result watcher: oldest note against the data of each acknowledged read
    always @(posedge ref_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            check(avs_readdata, exp_q.pop_front());
    end

    task set_file(input logic [6:0] fa, input logic [7:0] v);
        bus_wr(`OFS_FILE_ADDR, {25'h0000000, fa}, 4'hF);
        bus_wr(`OFS_FILE_DATA, {24'h000000, v}, 4'hF);
        model_file[fa] = v;
    endtask : set_file

    task set_state(input logic [7:0] acc, input logic [2:0] flg);
        bus_wr(`OFS_ACC, {24'h000000, acc}, 4'hF);
        bus_wr(`OFS_FLAGS, {29'h00000000, flg}, 4'hF);
        model_acc   = acc;
        model_flags = flg;
    endtask : set_state

    task verify_all(input logic [6:0] fa);
        bus_rd(`OFS_ACC, {24'h000000, model_acc});
        bus_rd(`OFS_FLAGS, {29'h00000000, model_flags});
        bus_rd(`OFS_PTR0, {16'h0000, model_ptr[0]});
        bus_rd(`OFS_PTR1, {16'h0000, model_ptr[1]});
        bus_wr(`OFS_FILE_ADDR, {25'h0000000, fa}, 4'hF);
        bus_rd(`OFS_FILE_DATA, {24'h000000, model_file[fa]});
        bus_rd(`OFS_STATE, {24'h000000, model_op, 4'h0});
    endtask : verify_all

    task run_cmd(input logic [3:0] op, input logic [7:0] lit, input logic [6:0] fa,
                 input logic dest, input logic psel);
        alu_subset_pkg::cmd_type cmd;
        logic [7:0]              a;
        logic [7:0]              f;
        logic [7:0]              r;
        logic [8:0]              sum;
        logic [4:0]              low;
        logic                    cin;
        cmd.ptr_sel   = psel;
        cmd.dest      = dest;
        cmd.file_addr = fa;
        cmd.literal   = lit;
        cmd.op        = alu_subset_pkg::op_type'(op);
        bus_wr(`OFS_CMD, {11'h000, cmd}, 4'hF);
        model_op = op;
        a   = model_acc;
        f   = (op == 4'h3) ? lit : model_file[fa];
        cin = (op == 4'h7) ? model_flags[0] : 1'b0;
        sum = {1'b0, a} + {1'b0, f} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, f[3:0]} + {4'h0, cin};
        r   = 8'h00;
        case (op)
            4'h1: model_ptr[psel] = model_ptr[psel] + {{10{lit[5]}}, lit[5:0]};
            4'h2: r = a & lit;
            4'h4: r = a & f;
            4'h3, 4'h5, 4'h7: begin
                r              = sum[7:0];
                model_flags[0] = sum[8];
                model_flags[1] = low[4];
            end
            4'h6: begin
                r              = {f[7], f[7:1]};
                model_flags[0] = f[0];
            end
            default: ;
        endcase
        if (op >= 4'h2 && op <= 4'h7) begin
            model_flags[2] = (r == 8'h00);
            if (op <= 4'h3 || !dest)
                model_acc = r;
            else
                model_file[fa] = r;
        end
    endtask : run_cmd

    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        conclude();
    end

    initial begin
        rst_n          = 1'b0;
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h00000000;
        avs_byteenable = 4'h0;
        bad_count      = 0;
        compares       = 0;
        model_acc      = 8'h00;
        model_flags    = 3'h0;
        model_ptr[0]   = 16'h0000;
        model_ptr[1]   = 16'h0000;
        model_op       = 4'h0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        void'($urandom(32'hB9C8));
        // File data is not reset, so skip that offset
        for (int i = 0; i < 8; i++)
            if (i != 6)
                bus_rd(8'(i * 4), 32'h00000000);
        bus_wr(8'h20, 32'hFFFFFFFF, 4'hF);
        bus_rd(8'h20, 32'h00000000);
        bus_rd(8'h02, 32'h00000000);
        for (int i = 0; i < 128; i++)
            set_file(7'(i), 8'($urandom));
        bus_wr(`OFS_PTR0, 32'h0000FFFF, 4'hF);
        model_ptr[0] = 16'hFFFF;
        run_cmd(4'h1, 8'h01, 7'h00, 1'b0, 1'b0);
        run_cmd(4'h1, 8'h20, 7'h00, 1'b0, 1'b1);
        run_cmd(4'h1, 8'h1F, 7'h00, 1'b0, 1'b1);
        verify_all(7'h00);
        set_state(8'hFF, 3'h0);
        run_cmd(4'h3, 8'h01, 7'h00, 1'b0, 1'b0);
        verify_all(7'h00);
        set_file(7'h7F, 8'h00);
        set_state(8'h0F, 3'h1);
        run_cmd(4'h7, 8'h00, 7'h7F, 1'b1, 1'b0);
        verify_all(7'h7F);
        set_file(7'h05, 8'h81);
        run_cmd(4'h6, 8'h00, 7'h05, 1'b0, 1'b0);
        run_cmd(4'h6, 8'h00, 7'h05, 1'b1, 1'b0);
        verify_all(7'h05);
        set_state(8'hAA, 3'h3);
        run_cmd(4'h2, 8'h55, 7'h00, 1'b0, 1'b0);
        verify_all(7'h00);
        set_state(8'h3C, 3'h6);
        run_cmd(4'h4, 8'h00, 7'h05, 1'b1, 1'b0);
        run_cmd(4'h5, 8'h00, 7'h05, 1'b1, 1'b0);
        run_cmd(4'h7, 8'h00, 7'h05, 1'b0, 1'b0);
        run_cmd(4'h5, 8'h00, 7'h05, 1'b0, 1'b0);
        // Undecoded op code leaves accumulator, flags, pointers and file alone
        run_cmd(4'h9, 8'hFF, 7'h05, 1'b1, 1'b1);
        verify_all(7'h05);
        bus_wr(`OFS_PTR0, 32'h0000ABCD, 4'h1);
        model_ptr[0][7:0] = 8'hCD;
        // Command without all three low lanes must be dropped
        bus_wr(`OFS_CMD, 32'h00000013, 4'h3);
        verify_all(7'h00);
        for (int n = 0; n < 150; n++) begin
            set_state(8'($urandom), 3'($urandom));
            rand_fa = 7'($urandom);
            run_cmd(4'($urandom), 8'($urandom), rand_fa, 1'($urandom), 1'($urandom));
            verify_all(rand_fa);
        end
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus_rd(`OFS_ACC, 32'h00000000);
        bus_rd(`OFS_PTR1, 32'h00000000);
        repeat (4) @(posedge ref_clk);
        conclude();
    end

endmodule : tb
